//--- rx_chain_cfg_regs.sv
// Receive chain configuration register bank with decoded control outputs.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module rx_chain_cfg_regs (
  input  wire  logic                                 I_REF_CLK,
  input  wire  logic                                 I_SRST,
  input  wire  logic [rx_chain_cfg_pkg::ADDR_W-1:0]  I_ADDR,
  input  wire  logic [rx_chain_cfg_pkg::DATA_W-1:0]  I_WDATA,
  input  wire  logic                                 I_WR,
  input  wire  logic                                 I_RD,
  output var   logic [rx_chain_cfg_pkg::DATA_W-1:0]  O_RDATA,
  output var   logic [rx_chain_cfg_pkg::NUM_CH-1:0]  O_CHANNEL_POWER_DOWN,
  output var   logic [2*rx_chain_cfg_pkg::NUM_CH-1:0] O_CHANNEL_INPUT_GAIN,
  output var   logic                                 O_LOW_POWER_MODE,
  output var   logic                                 O_MIDDLE_POWER_MODE,
  output var   logic                                 O_LOW_NOISE_MODE,
  output var   logic                                 O_ATTEN_GAINSTAGE_POWER_DOWN,
  output var   logic                                 O_INPUT_AMP_POWER_DOWN,
  output var   logic                                 O_CHAIN_PARTIAL_POWER_DOWN,
  output var   logic                                 O_CHAIN_FULL_POWER_DOWN,
  output var   logic [4:0]                           O_SUMMING_AMP_GAIN_SELECT,
  output var   logic                                 O_FAST_CLOCK_CMOS,
  output var   logic                                 O_BASE_CLOCK_CMOS,
  output var   logic                                 O_CONTINUOUS_WAVE_MODE,
  output var   logic                                 O_SUMMING_AMP_ON,
  output var   logic [3:0]                           O_MIXER_CLOCK_MODE,
  output var   logic [4*rx_chain_cfg_pkg::NUM_CH-1:0] O_CHANNEL_MIXER_PHASE,
  output var   logic [1:0]                           O_HIGHPASS_CORNER_SELECT,
  output var   logic                                 O_DIGITAL_ATTEN_ENABLE,
  output var   logic [2:0]                           O_DIGITAL_ATTEN_AMOUNT,
  output var   logic                                 O_GAINSTAGE_TEST_ROUTE,
  output var   logic [5*rx_chain_cfg_pkg::NUM_CH-1:0] O_TERMINATION_RESISTOR_ENABLE
);
  import rx_chain_cfg_pkg::*;

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [DATA_W-1:0] input_amp_termination_control;
  logic [DATA_W-1:0] channel_power_control;
  logic [DATA_W-1:0] mixer_clock_config;
  logic [DATA_W-1:0] mixer_phase_ch1_to_4;
  logic [DATA_W-1:0] mixer_phase_ch5_to_8;
  logic [DATA_W-1:0] per_channel_input_gain;
  logic [DATA_W-1:0] filter_atten_test_config;

  wire hit_term   = (I_ADDR == OFS_INPUT_AMP_TERMINATION_CONTROL);
  wire hit_power  = (I_ADDR == OFS_CHANNEL_POWER_CONTROL);
  wire hit_clock  = (I_ADDR == OFS_MIXER_CLOCK_CONFIG);
  wire hit_phase0 = (I_ADDR == OFS_MIXER_PHASE_CH1_TO_4);
  wire hit_phase1 = (I_ADDR == OFS_MIXER_PHASE_CH5_TO_8);
  wire hit_gain   = (I_ADDR == OFS_PER_CHANNEL_INPUT_GAIN);
  wire hit_filter = (I_ADDR == OFS_FILTER_ATTEN_TEST_CONFIG);

  wire [DATA_W-1:0] read_mux =
      hit_term   ? input_amp_termination_control :
      hit_power  ? channel_power_control :
      hit_clock  ? mixer_clock_config :
      hit_phase0 ? mixer_phase_ch1_to_4 :
      hit_phase1 ? mixer_phase_ch5_to_8 :
      hit_gain   ? per_channel_input_gain :
      hit_filter ? filter_atten_test_config : RESET_VALUE;

  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      input_amp_termination_control <= RESET_VALUE;
      channel_power_control         <= RESET_VALUE;
      mixer_clock_config            <= RESET_VALUE;
      mixer_phase_ch1_to_4          <= RESET_VALUE;
      mixer_phase_ch5_to_8          <= RESET_VALUE;
      per_channel_input_gain        <= RESET_VALUE;
      filter_atten_test_config      <= RESET_VALUE;
    end else if (I_WR) begin
      if (hit_term)   input_amp_termination_control <= I_WDATA & MASK_TERMINATION;
      if (hit_power)  channel_power_control         <= I_WDATA & MASK_POWER;
      if (hit_clock)  mixer_clock_config            <= I_WDATA & MASK_MIXER_CLOCK;
      if (hit_phase0) mixer_phase_ch1_to_4          <= I_WDATA & MASK_FULL;
      if (hit_phase1) mixer_phase_ch5_to_8          <= I_WDATA & MASK_FULL;
      if (hit_gain)   per_channel_input_gain        <= I_WDATA & MASK_FULL;
      if (hit_filter) filter_atten_test_config      <= I_WDATA & MASK_FILTER;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_RDATA <= RESET_VALUE;
    end else begin
      O_RDATA <= I_RD ? read_mux : RESET_VALUE;
    end
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  wire       per_channel_gain_enable = input_amp_termination_control[GAIN_INDIV_BIT];
  wire [1:0] common_gain = input_amp_termination_control[COMMON_GAIN_LSB +: 2];
  wire       term_enable = input_amp_termination_control[TERM_ENABLE_BIT];
  wire       term_indiv  = input_amp_termination_control[TERM_INDIV_BIT];
  wire [1:0] term_preset = input_amp_termination_control[TERM_PRESET_LSB +: 2];
  wire [4:0] term_bits   = input_amp_termination_control[TERM_RES_LSB +: 5];

  wire low_power_bit   = channel_power_control[LOW_POWER_BIT];
  wire middle_power_select = channel_power_control[MID_POWER_BIT];
  wire partial_pd_bit  = channel_power_control[PARTIAL_PD_BIT];
  wire chain_full_power_down = channel_power_control[FULL_PD_BIT];

  wire path_select          = mixer_clock_config[PATH_SEL_BIT];
  wire summing_amp_disable_n = mixer_clock_config[SUM_DIS_N_BIT];
  wire [1:0] mixer_clock_mode = mixer_clock_config[CLK_MODE_LSB +: 2];

  wire       digital_atten_enable = filter_atten_test_config[ATTEN_EN_BIT];
  wire [2:0] digital_atten_amount = filter_atten_test_config[ATTEN_AMT_LSB +: 3];
  wire       summing_amp_power    = filter_atten_test_config[SUM_POWER_BIT];
  wire       gainstage_test_route = filter_atten_test_config[TEST_ROUTE_BIT];

  // ==========================================================================
  // Decoding
  // ==========================================================================
  // Preset patterns approximate the nominal impedance at each gain except 50 ohm at 12 dB, which is high impedance.
  function automatic logic [4:0] term_decode(input logic [1:0] gain, input logic [1:0] preset);
    logic [4:0] pattern;
    pattern = TERM_18DB[preset];
    case (gain)
      GAIN_24DB: pattern = TERM_24DB[preset];
      GAIN_12DB: pattern = TERM_12DB[preset];
      default:   pattern = TERM_18DB[preset];
    endcase
    return pattern;
  endfunction

  logic [2*NUM_CH-1:0] next_gain;
  logic [5*NUM_CH-1:0] next_term;
  always_comb begin
    next_gain = '0;
    next_term = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_gain[2*ch +: 2] = per_channel_gain_enable ? per_channel_input_gain[2*ch +: 2]
                                                     : common_gain;
      if (!term_enable) begin
        next_term[5*ch +: 5] = 5'h00;
      end else if (term_indiv) begin
        next_term[5*ch +: 5] = term_bits;
      end else begin
        next_term[5*ch +: 5] = term_decode(next_gain[2*ch +: 2], term_preset);
      end
    end
  end

  // power mode select
  // A conflicting setting of both bits falls back to low noise.
  wire next_low_power = low_power_bit & ~middle_power_select;
  wire next_mid_power = middle_power_select & ~low_power_bit;

  wire next_partial = partial_pd_bit & ~chain_full_power_down;

  // summing amplifier state
  // The test-route power bit is honoured only while in time-gain mode.
  wire next_sum_on = path_select ? ~summing_amp_disable_n
                                 : (gainstage_test_route & summing_amp_power);

  wire [3:0] next_clk_mode = (mixer_clock_mode == 2'h0) ? CLK_MODE_16X :
                             (mixer_clock_mode == 2'h1) ? CLK_MODE_8X :
                             (mixer_clock_mode == 2'h2) ? CLK_MODE_4X : CLK_MODE_1X;

  wire [2:0] next_atten = digital_atten_enable ? digital_atten_amount : 3'h0;

  // ==========================================================================
  // Output registers
  // ==========================================================================
  always_ff @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_CHANNEL_POWER_DOWN          <= '0;
      O_CHANNEL_INPUT_GAIN          <= '0;
      O_LOW_POWER_MODE              <= 1'b0;
      O_MIDDLE_POWER_MODE           <= 1'b0;
      O_LOW_NOISE_MODE              <= 1'b1;
      O_ATTEN_GAINSTAGE_POWER_DOWN  <= 1'b0;
      O_INPUT_AMP_POWER_DOWN        <= 1'b0;
      O_CHAIN_PARTIAL_POWER_DOWN    <= 1'b0;
      O_CHAIN_FULL_POWER_DOWN       <= 1'b0;
      O_SUMMING_AMP_GAIN_SELECT     <= '0;
      O_FAST_CLOCK_CMOS             <= 1'b0;
      O_BASE_CLOCK_CMOS             <= 1'b1;
      O_CONTINUOUS_WAVE_MODE        <= 1'b0;
      O_SUMMING_AMP_ON              <= 1'b0;
      O_MIXER_CLOCK_MODE            <= CLK_MODE_16X;
      O_CHANNEL_MIXER_PHASE         <= '0;
      O_HIGHPASS_CORNER_SELECT      <= '0;
      O_DIGITAL_ATTEN_ENABLE        <= 1'b0;
      O_DIGITAL_ATTEN_AMOUNT        <= '0;
      O_GAINSTAGE_TEST_ROUTE        <= 1'b0;
      O_TERMINATION_RESISTOR_ENABLE <= '0;
    end else begin
      O_CHANNEL_POWER_DOWN          <= channel_power_control[CH_PD_LSB +: NUM_CH];
      O_CHANNEL_INPUT_GAIN          <= next_gain;
      O_LOW_POWER_MODE              <= next_low_power;
      O_MIDDLE_POWER_MODE           <= next_mid_power;
      O_LOW_NOISE_MODE              <= ~(next_low_power | next_mid_power);
      O_ATTEN_GAINSTAGE_POWER_DOWN  <= channel_power_control[ATTEN_PD_BIT];
      O_INPUT_AMP_POWER_DOWN        <= channel_power_control[INAMP_PD_BIT];
      O_CHAIN_PARTIAL_POWER_DOWN    <= next_partial;
      O_CHAIN_FULL_POWER_DOWN       <= chain_full_power_down;
      O_SUMMING_AMP_GAIN_SELECT     <= mixer_clock_config[SUM_GAIN_LSB +: 5];
      O_FAST_CLOCK_CMOS             <= mixer_clock_config[FAST_CLK_BIT];
      O_BASE_CLOCK_CMOS             <= ~mixer_clock_config[BASE_CLK_BIT];
      O_CONTINUOUS_WAVE_MODE        <= path_select;
      O_SUMMING_AMP_ON              <= next_sum_on;
      O_MIXER_CLOCK_MODE            <= next_clk_mode;
      O_CHANNEL_MIXER_PHASE         <= {mixer_phase_ch5_to_8, mixer_phase_ch1_to_4};
      O_HIGHPASS_CORNER_SELECT      <= filter_atten_test_config[HPF_LSB +: 2];
      O_DIGITAL_ATTEN_ENABLE        <= digital_atten_enable;
      O_DIGITAL_ATTEN_AMOUNT        <= next_atten;
      O_GAINSTAGE_TEST_ROUTE        <= gainstage_test_route;
      O_TERMINATION_RESISTOR_ENABLE <= next_term;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);

  sequence seq_gain_write_indiv;
    I_WR && hit_gain && per_channel_gain_enable;
  endsequence

  sequence seq_power_write;
    I_WR && hit_power;
  endsequence

  AST_CHANNEL_GAIN_FOLLOWS: assert property (
    seq_gain_write_indiv |-> ##2 O_CHANNEL_INPUT_GAIN == $past(I_WDATA, 2))
    else $error("Channel gain did not follow its own field.");

  AST_COMMON_GAIN_USED: assert property (
    !per_channel_gain_enable ##1 !per_channel_gain_enable
      |-> O_CHANNEL_INPUT_GAIN == {NUM_CH{$past(common_gain)}})
    else $error("Common gain not applied to all channels.");

  AST_POWER_DOWN_WRITE: assert property (
    seq_power_write
      |-> ##2 O_CHANNEL_POWER_DOWN == $past(I_WDATA[NUM_CH-1:0], 2))
    else $error("Channel power-down does not match written value.");

  AST_POWER_MODE_EXCLUSIVE: assert property (
    $onehot({O_LOW_POWER_MODE, O_MIDDLE_POWER_MODE, O_LOW_NOISE_MODE}))
    else $error("Power modes are not mutually exclusive.");

  AST_MIDDLE_POWER_SET: assert property (
    seq_power_write ##0 (I_WDATA[MID_POWER_BIT] && !I_WDATA[LOW_POWER_BIT]) ##1 !I_WR
      |=> O_MIDDLE_POWER_MODE && !O_LOW_NOISE_MODE)
    else $error("Medium power mode not entered.");

  AST_FULL_OVERRIDES: assert property (
    O_CHAIN_FULL_POWER_DOWN |-> !O_CHAIN_PARTIAL_POWER_DOWN)
    else $error("Partial power-down active under full power-down.");

  AST_SUMMING_CW: assert property (
    O_CONTINUOUS_WAVE_MODE |-> O_SUMMING_AMP_ON == !$past(summing_amp_disable_n))
    else $error("Summing amplifier enable wrong in continuous-wave mode.");

  AST_SUMMING_TEST: assert property (
    (!O_CONTINUOUS_WAVE_MODE && !O_GAINSTAGE_TEST_ROUTE) |-> !O_SUMMING_AMP_ON)
    else $error("Summing amplifier on outside its active modes.");

  AST_CLOCK_MODE_ONEHOT: assert property (
    $onehot(O_MIXER_CLOCK_MODE))
    else $error("Mixer clock mode is not one-hot.");

  AST_CLOCK_MODE: assert property (
    $past(mixer_clock_mode) == 2'h3 |-> O_MIXER_CLOCK_MODE == CLK_MODE_1X)
    else $error("Mixer clock mode decode wrong.");

  AST_ATTEN_POWER_DOWN: assert property (
    O_ATTEN_GAINSTAGE_POWER_DOWN == $past(channel_power_control[ATTEN_PD_BIT]))
    else $error("Attenuator power-down does not follow its bit.");

  AST_INPUT_AMP_POWER_DOWN: assert property (
    O_INPUT_AMP_POWER_DOWN == $past(channel_power_control[INAMP_PD_BIT]))
    else $error("Input amplifier power-down does not follow its bit.");

  AST_PARTIAL_POWER_DOWN: assert property (
    $past(partial_pd_bit && !chain_full_power_down) |-> O_CHAIN_PARTIAL_POWER_DOWN)
    else $error("Partial power-down not applied.");

  AST_SUMMING_GAIN: assert property (
    O_SUMMING_AMP_GAIN_SELECT == $past(mixer_clock_config[SUM_GAIN_LSB +: 5]))
    else $error("Summing gain select does not follow its field.");

  AST_FAST_CLOCK_TYPE: assert property (
    O_FAST_CLOCK_CMOS == $past(mixer_clock_config[FAST_CLK_BIT]))
    else $error("Fast clock input type wrong.");

  AST_BASE_CLOCK_TYPE: assert property (
    O_BASE_CLOCK_CMOS != $past(mixer_clock_config[BASE_CLK_BIT]))
    else $error("Base clock input type polarity wrong.");

  AST_PATH_SELECT: assert property (
    O_CONTINUOUS_WAVE_MODE == $past(path_select))
    else $error("Path select does not follow its bit.");

  AST_PHASE_ORDER: assert property (
    O_CHANNEL_MIXER_PHASE[4*NUM_CH-1 -: 4] == $past(mixer_phase_ch5_to_8[DATA_W-1 -: 4]))
    else $error("Last channel phase not in the top nibble.");

  AST_HIGHPASS_CORNER: assert property (
    O_HIGHPASS_CORNER_SELECT == $past(filter_atten_test_config[HPF_LSB +: 2]))
    else $error("High-pass corner select does not follow its field.");

  AST_TEST_ROUTE: assert property (
    O_GAINSTAGE_TEST_ROUTE == $past(gainstage_test_route))
    else $error("Gain stage test routing does not follow its bit.");

  AST_ATTEN_GATED: assert property (
    !O_DIGITAL_ATTEN_ENABLE |-> O_DIGITAL_ATTEN_AMOUNT == 3'h0)
    else $error("Attenuation applied while disabled.");

  AST_HIGH_Z_12DB: assert property (
    $past(term_enable && !term_indiv && term_preset == 2'h0 && common_gain == GAIN_12DB
          && !per_channel_gain_enable)
      |-> O_TERMINATION_RESISTOR_ENABLE == '0)
    else $error("Preset 50 ohm at 12 dB must be high impedance.");

  AST_TERM_INDIV: assert property (
    $past(term_enable && term_indiv)
      |-> O_TERMINATION_RESISTOR_ENABLE == {NUM_CH{$past(term_bits)}})
    else $error("Individual termination bits not applied.");

  AST_READ_BACK: assert property (
    I_WR && hit_power ##1 I_RD && hit_power
      |=> O_RDATA == ($past(I_WDATA, 2) & MASK_POWER))
    else $error("Read-back of power register wrong.");

  AST_IDLE_READ_ZERO: assert property (
    !I_RD |=> O_RDATA == RESET_VALUE)
    else $error("Read data present without a read strobe.");

endmodule

`default_nettype wire

//--- rx_chain_cfg_pkg.sv
// Register map, field positions and encodings of the receive chain configuration bank.
package rx_chain_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 8;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_INPUT_AMP_TERMINATION_CONTROL = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_POWER_CONTROL         = 8'h35;
  localparam logic [ADDR_W-1:0] OFS_MIXER_CLOCK_CONFIG            = 8'h36;
  localparam logic [ADDR_W-1:0] OFS_MIXER_PHASE_CH1_TO_4          = 8'h37;
  localparam logic [ADDR_W-1:0] OFS_MIXER_PHASE_CH5_TO_8          = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_PER_CHANNEL_INPUT_GAIN        = 8'h39;
  localparam logic [ADDR_W-1:0] OFS_FILTER_ATTEN_TEST_CONFIG      = 8'h3b;

  // Writable bits of each register; reserved bits store nothing and read zero.
  localparam logic [DATA_W-1:0] MASK_TERMINATION = 16'hf7ff;
  localparam logic [DATA_W-1:0] MASK_POWER       = 16'hfcff;
  localparam logic [DATA_W-1:0] MASK_MIXER_CLOCK = 16'h0f7f;
  localparam logic [DATA_W-1:0] MASK_FULL        = 16'hffff;
  localparam logic [DATA_W-1:0] MASK_FILTER      = 16'h03fc;
  localparam logic [DATA_W-1:0] RESET_VALUE      = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TERM_RES_LSB    = 0;
  localparam int TERM_INDIV_BIT  = 5;
  localparam int TERM_PRESET_LSB = 6;
  localparam int TERM_ENABLE_BIT = 8;
  localparam int COMMON_GAIN_LSB = 13;
  localparam int GAIN_INDIV_BIT  = 15;
  localparam int CH_PD_LSB       = 0;
  localparam int LOW_POWER_BIT   = 10;
  localparam int MID_POWER_BIT   = 11;
  localparam int ATTEN_PD_BIT    = 12;
  localparam int INAMP_PD_BIT    = 13;
  localparam int PARTIAL_PD_BIT  = 14;
  localparam int FULL_PD_BIT     = 15;
  localparam int SUM_GAIN_LSB    = 0;
  localparam int FAST_CLK_BIT    = 5;
  localparam int BASE_CLK_BIT    = 6;
  localparam int PATH_SEL_BIT    = 8;
  localparam int SUM_DIS_N_BIT   = 9;
  localparam int CLK_MODE_LSB    = 10;
  localparam int HPF_LSB         = 2;
  localparam int ATTEN_AMT_LSB   = 4;
  localparam int ATTEN_EN_BIT    = 7;
  localparam int SUM_POWER_BIT   = 8;
  localparam int TEST_ROUTE_BIT  = 9;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  localparam logic [1:0] GAIN_18DB = 2'h0;
  localparam logic [1:0] GAIN_24DB = 2'h1;
  localparam logic [1:0] GAIN_12DB = 2'h2;

  // Mixer clock mode, one-hot: bit0 16x, bit1 8x, bit2 4x, bit3 1x.
  localparam logic [3:0] CLK_MODE_16X = 4'h1;
  localparam logic [3:0] CLK_MODE_8X  = 4'h2;
  localparam logic [3:0] CLK_MODE_4X  = 4'h4;
  localparam logic [3:0] CLK_MODE_1X  = 4'h8;

  // Preset termination resistor patterns (50, 100, 200, 400 ohm) per gain.
  localparam logic [4:0] TERM_24DB [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
  localparam logic [4:0] TERM_18DB [4] = '{5'h07, 5'h0e, 5'h1c, 5'h04};
  localparam logic [4:0] TERM_12DB [4] = '{5'h00, 5'h03, 5'h06, 5'h0c};

endpackage

//--- testbench.sv
// Self-checking testbench for the receive chain configuration bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rx_chain_cfg_pkg::*;
  logic        clk = 1'b0;
  logic        rst, wr, rd;
  logic [7:0]  addr;
  logic [15:0] wdata;
  wire  [15:0] rdata, gain;
  wire  [7:0]  chpd;
  wire  [4:0]  sgain;
  wire  [3:0]  cmode;
  wire  [31:0] phase;
  wire  [39:0] term;
  wire  [2:0]  amt;
  wire  [1:0]  hpf;
  wire         lowp, midp, lown, apd, ipd, ppd, fpd, fcmos, bcmos, cw, son, aen, trt;
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [7:0]  ofs [7] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3b};
  logic [15:0] msk [7] = '{MASK_TERMINATION, MASK_POWER, MASK_MIXER_CLOCK, MASK_FULL,
                           MASK_FULL, MASK_FULL, MASK_FILTER};
  logic [15:0] pw_in [4] = '{16'h0401, 16'h0880, 16'h5000, 16'h9000};
  logic [14:0] pw_ex [4] = '{15'h00c0, 15'h4020, 15'h001a, 15'h0019};

  rx_chain_cfg_regs i_rx_chain_cfg_regs (
    .I_REF_CLK(clk), .I_SRST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_CHANNEL_POWER_DOWN(chpd), .O_CHANNEL_INPUT_GAIN(gain),
    .O_LOW_POWER_MODE(lowp), .O_MIDDLE_POWER_MODE(midp), .O_LOW_NOISE_MODE(lown),
    .O_ATTEN_GAINSTAGE_POWER_DOWN(apd), .O_INPUT_AMP_POWER_DOWN(ipd),
    .O_CHAIN_PARTIAL_POWER_DOWN(ppd), .O_CHAIN_FULL_POWER_DOWN(fpd),
    .O_SUMMING_AMP_GAIN_SELECT(sgain), .O_FAST_CLOCK_CMOS(fcmos), .O_BASE_CLOCK_CMOS(bcmos),
    .O_CONTINUOUS_WAVE_MODE(cw), .O_SUMMING_AMP_ON(son), .O_MIXER_CLOCK_MODE(cmode),
    .O_CHANNEL_MIXER_PHASE(phase), .O_HIGHPASS_CORNER_SELECT(hpf),
    .O_DIGITAL_ATTEN_ENABLE(aen), .O_DIGITAL_ATTEN_AMOUNT(amt),
    .O_GAINSTAGE_TEST_ROUTE(trt), .O_TERMINATION_RESISTOR_ENABLE(term)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // ==========================================================================
  // Bus tasks and comparison
  // ==========================================================================
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand for one cycle only, so they are sampled just after the answering edge.
  task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(40'(rdata), 40'(exp));
  endtask

  // Write then read with no idle cycle between, which the bus allows.
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(40'(rdata), 40'(exp));
  endtask

  // Decoded outputs follow the register by exactly one edge.
  task automatic step(input logic [7:0] a, input logic [15:0] d);
    wreg(a, d);
    @(posedge clk);
    #1;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) rreg(ofs[i], 16'h0000);
    check(40'({lown, bcmos, cmode, son}), 40'h62);
    $display("reset test done");
    wreg(8'h3a, 16'hffff);
    foreach (ofs[i]) wreg(ofs[i], 16'hffff);
    foreach (ofs[i]) rreg(ofs[i], msk[i]);
    rreg(8'h3a, 16'h0000);
    check(40'({lowp, midp, lown, fpd, ppd}), 40'h06);
    check(40'({chpd, apd, ipd}), 40'h3ff);
    check(40'({cw, son, cmode, fcmos, bcmos, sgain}), 40'h145f);
    check(40'({aen, amt, hpf, trt}), 40'h7f);
    check(40'(gain), 40'hffff);
    check(term, {8{5'h1f}});
    $display("access test done");
    wrrd(8'h35, 16'h0401, 16'h0401);
    foreach (pw_in[i]) begin
      step(8'h35, pw_in[i]);
      check(40'({chpd, lowp, midp, lown, apd, ipd, ppd, fpd}), 40'(pw_ex[i]));
    end
    $display("power test done");
    for (int k = 0; k < 4; k++) begin
      step(8'h36, 16'(k << 10));
      check(40'(cmode), 40'(4'h1 << k));
    end
    check(40'({cw, son}), 40'h1);
    step(8'h3b, 16'h0254);
    check(40'({aen, amt, hpf, trt, son}), 40'h06);
    step(8'h3b, 16'h00d4);
    check(40'({aen, amt, hpf, trt, son}), 40'hd4);
    step(8'h36, 16'h0100);
    check(40'({cw, son}), 40'h3);
    step(8'h36, 16'h0340);
    check(40'({cw, son, bcmos}), 40'h4);
    step(8'h37, 16'h3210);
    step(8'h38, 16'h7654);
    check(40'(phase), 40'h76543210);
    $display("mixer test done");
    step(8'h34, 16'h2140);
    check(40'(gain), 40'h5555);
    check(term, {8{5'h02}});
    step(8'h39, 16'h0002);
    step(8'h34, 16'ha100);
    check(40'(gain), 40'h0002);
    check(term, {{7{5'h07}}, 5'h00});
    step(8'h34, 16'ha12a);
    check(term, {8{5'h0a}});
    step(8'h34, 16'h002a);
    check(term, 40'h0);
    step(8'h34, 16'h4100);
    check(40'(gain), 40'haaaa);
    check(term, 40'h0);
    $display("termination test done");
    test_done();
  end
endmodule
`default_nettype wire
